// File: common/short_fault_pkg.sv
// constants shared by the short-fault register logic
package short_fault_pkg;
	localparam int FAULT_WIDTH = 10;
	// fault register bit positions, shift order from first to last
	localparam int BIT_A_HIGH = 0;
	localparam int BIT_B_HIGH = 1;
	localparam int BIT_C_HIGH = 2;
	localparam int BIT_A_LOW  = 3;
	localparam int BIT_B_LOW  = 4;
	localparam int BIT_C_LOW  = 5;
	localparam int BIT_REG_UV = 6;
	localparam int BIT_A_BOOT = 7;
	localparam int BIT_B_BOOT = 8;
	localparam int BIT_C_BOOT = 9;
	localparam logic [9:0] FAULT_RESET = 10'h000;
	// reference clock and fault blank time
	localparam int REF_CLK_HZ   = 20_000_000;
	localparam int BLANK_TIME_NS = 2000;
	localparam int BLANK_CYCLES = (BLANK_TIME_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int PTR_WIDTH    = 4;
	localparam logic [3:0] LAST_INDEX = 4'h9;
	// serial readout states
	typedef enum logic [2:0] {
		READ_IDLE  = 3'b001,
		READ_SHIFT = 3'b010,
		READ_DONE  = 3'b100
	} read_state_type;
endpackage : short_fault_pkg

// File: core/sync_two_flop.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sync_two_flop #(
	parameter int WIDTH = 1
) (
	// clock and control
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             enable,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] first_stage;

	always_ff @(posedge clk) begin
		if (reset) begin
			first_stage <= '0;
			sync_out    <= '0;
		end else if (enable) begin
			first_stage <= async_in;
			sync_out    <= first_stage;
		end
	end
endmodule : sync_two_flop

// File: core/fet_blank_qualifier.sv
// qualifies one drain-source comparator by FET activity and blank time
`timescale 1ns/10ps
module fet_blank_qualifier #(
	parameter int BLANK = short_fault_pkg::BLANK_CYCLES
) (
	// clock and control
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic enable,
	// fet status
	input  wire logic fet_on,
	input  wire logic over_threshold,
	output logic      short_seen
);
	localparam int CW = $clog2(BLANK + 1);
	logic [CW-1:0] blank_count;
	wire           blanked = (blank_count != CW'(BLANK));

	always_ff @(posedge clk) begin
		if (reset) begin
			blank_count <= '0;
		end else if (enable) begin
			if (!fet_on)
				blank_count <= '0;
			else if (blanked)
				blank_count <= blank_count + CW'(1);
		end
	end

	// ignored while the fet is off and until the blank time ends
	assign short_seen = fet_on && !blanked && over_threshold;

	AST_BLANK_HOLDS: assert property (@(posedge clk) disable iff (reset)
		$rose(fet_on) |-> !short_seen) else $error("short seen inside blank time");
endmodule : fet_blank_qualifier

// File: core/bridge_short_fault_register.sv
// short-fault detection, fault flags and serial fault register readout
// Notes on behaviour
// - shutdown enable low: shorts neither latch the flag nor disable the FETs; flag live.
// - every short is stored in the register even with shutdown enable low.
// - low-side comparators ignored while FET off and for one blank time.
// - qualified short raises clock flag; with shutdown enable high latches and disables gates.
// - high-side comparators qualified the same way detect shorts to ground.
// - shorted winding shows as simultaneous high and low side bits.
// - flags only say probable short; register gives type and location.
// - ten bits: three high shorts, three low shorts, regulator uv, three boot uv.
// - bits accumulate; clear only on reset, power cycle, or completed read.
// - logic supply undervoltage clears the register and shows both flags high.
// - serial access only while the clock flag is released high.
// - flags are open drain; released clock flag is sensed as shift clock.
// - controller pulling clock flag low starts read with first bit on data flag.
// - each high-low clock cycle presents the next bit, ten in all.
// - extra cycle after last bit clears register and flags, both driven low.
// - persisting unlatched faults show on the flags right after the clear; a live short shows one cycle later.
// - regulator uv bit latches independently and may stay set after power-on.
// - overtemperature releases data flag, keeps clock flag low until recovery.
// - boot undervoltage state latched until reset or completed read.
`timescale 1ns/10ps
module bridge_short_fault_register #(
	parameter int BLANK = short_fault_pkg::BLANK_CYCLES
) (
	// clock, reset and enable
	input  wire logic       REF_CLK,
	input  wire logic       RESET,
	input  wire logic       CLK_EN,
	// device reset pin, active low, from outside
	input  wire logic       RESET_N_PIN,
	// configuration
	input  wire logic       SHUTDOWN_ON_FAULT,
	// fet activity and comparators: bit 0 phase a, 1 b, 2 c
	input  wire logic [2:0] HIGH_FET_ON,
	input  wire logic [2:0] LOW_FET_ON,
	input  wire logic [2:0] HIGH_OVER_THRESHOLD,
	input  wire logic [2:0] LOW_OVER_THRESHOLD,
	// supply and temperature monitors
	input  wire logic       REGULATOR_UV,
	input  wire logic       LOGIC_SUPPLY_UV,
	input  wire logic       OVER_TEMPERATURE,
	input  wire logic [2:0] BOOT_UV,
	// fault flag pins, open drain
	input  wire logic       FAULT_FLAG_DATA_IN,
	output logic            FAULT_FLAG_DATA_OUT,
	output logic            FAULT_FLAG_DATA_OE_N,
	input  wire logic       FAULT_FLAG_CLOCK_IN,
	output logic            FAULT_FLAG_CLOCK_OUT,
	output logic            FAULT_FLAG_CLOCK_OE_N,
	// gate drive disable
	output logic            GATES_DISABLED,
	// register view
	output logic [9:0]      FAULT_CAPTURE_SHIFT
);
	logic [9:0]     fault_capture_shift;
	logic           short_latched;
	logic           boot_latched;
	logic [3:0]     bit_index;
	logic           clock_pin_sync;
	logic           clock_pin_prev;
	logic           reset_n_sync;
	logic [5:0]     monitor_sync;
	logic [2:0]     high_short;
	logic [2:0]     low_short;
	logic [9:0]     next_fault;
	logic           next_short_latched;
	logic           next_boot_latched;
	short_fault_pkg::read_state_type read_state;
	short_fault_pkg::read_state_type next_read_state;
	logic [3:0]     next_bit_index;

	// synchronise the device reset pin and the clock flag pin
	sync_two_flop #(.WIDTH(2)) u_pin_sync (
		.clk     (REF_CLK),
		.reset   (RESET),
		.enable  (CLK_EN),
		.async_in({RESET_N_PIN, FAULT_FLAG_CLOCK_IN}),
		.sync_out({reset_n_sync, clock_pin_sync})
	);

	// analog monitor levels come from outside the clock domain
	sync_two_flop #(.WIDTH(6)) u_monitor_sync (
		.clk     (REF_CLK),
		.reset   (RESET),
		.enable  (CLK_EN),
		.async_in({REGULATOR_UV, LOGIC_SUPPLY_UV, OVER_TEMPERATURE, BOOT_UV}),
		.sync_out(monitor_sync)
	);
	wire       regulator_uv = monitor_sync[5];
	wire       logic_uv     = monitor_sync[4];
	wire       over_temp    = monitor_sync[3];
	wire [2:0] boot_uv      = monitor_sync[2:0];

	// per-fet qualification by activity and blank time
	genvar g;
	for (g = 0; g < 3; g++) begin : g_phase
		fet_blank_qualifier #(.BLANK(BLANK)) u_high (
			.clk           (REF_CLK),
			.reset         (RESET),
			.enable        (CLK_EN),
			.fet_on        (HIGH_FET_ON[g]),
			.over_threshold(HIGH_OVER_THRESHOLD[g]),
			.short_seen    (high_short[g])
		);
		fet_blank_qualifier #(.BLANK(BLANK)) u_low (
			.clk           (REF_CLK),
			.reset         (RESET),
			.enable        (CLK_EN),
			.fet_on        (LOW_FET_ON[g]),
			.over_threshold(LOW_OVER_THRESHOLD[g]),
			.short_seen    (low_short[g])
		);
	end

	// clock flag edges, valid only while the pin is released
	wire clock_fall = clock_pin_prev && !clock_pin_sync;
	wire any_short  = |high_short || |low_short;
	// shorts show both bits when a winding is shorted; no extra detector
	wire [9:0] new_faults = {boot_uv, regulator_uv, low_short, high_short};

	// flag levels before the serial read takes over the pins
	wire short_flag   = any_short || short_latched;
	wire uv_flag      = logic_uv || regulator_uv || boot_latched;
	wire clock_flag   = short_flag || uv_flag;
	wire data_flag    = uv_flag || over_temp;
	wire reading      = (read_state == short_fault_pkg::READ_SHIFT);
	wire read_allowed = clock_flag && !over_temp;
	wire read_end     = reading && clock_fall && bit_index == short_fault_pkg::LAST_INDEX;
	wire clear_all    = !reset_n_sync || read_end;

	// serial read sequencer
	always_comb begin
		next_read_state = read_state;
		next_bit_index  = bit_index;
		unique case (read_state)
			short_fault_pkg::READ_IDLE: begin
				if (read_allowed && clock_fall) begin
					next_read_state = short_fault_pkg::READ_SHIFT;
					next_bit_index  = 4'h0;
				end
			end
			short_fault_pkg::READ_SHIFT: begin
				if (clock_fall) begin
					if (bit_index == short_fault_pkg::LAST_INDEX)
						next_read_state = short_fault_pkg::READ_DONE;
					else
						next_bit_index = bit_index + 4'h1;
				end
			end
			short_fault_pkg::READ_DONE: begin
				// the controller still pulls the pin low here, so its release shows no
				// edge; leave at once or the flags would stay cleared for good
				next_read_state = short_fault_pkg::READ_IDLE;
			end
			default: next_read_state = short_fault_pkg::READ_IDLE;
		endcase
		if (logic_uv || !reset_n_sync)
			next_read_state = short_fault_pkg::READ_IDLE;
	end

	// register and latched fault states
	always_comb begin
		next_fault         = fault_capture_shift | new_faults;
		next_short_latched = short_latched ||
			(SHUTDOWN_ON_FAULT && any_short);
		next_boot_latched  = boot_latched || |boot_uv;
		if (clear_all) begin
			// a fault arriving in the clearing cycle is kept: set wins over clear
			next_fault         = new_faults;
			next_short_latched = SHUTDOWN_ON_FAULT && any_short;
			next_boot_latched  = |boot_uv;
		end
		if (logic_uv) begin
			next_fault         = short_fault_pkg::FAULT_RESET;
			next_short_latched = 1'b0;
			next_boot_latched  = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			fault_capture_shift <= short_fault_pkg::FAULT_RESET;
			short_latched       <= 1'b0;
			boot_latched        <= 1'b0;
			read_state          <= short_fault_pkg::READ_IDLE;
			bit_index           <= 4'h0;
			clock_pin_prev      <= 1'b0;
		end else if (CLK_EN) begin
			fault_capture_shift <= next_fault;
			short_latched       <= next_short_latched;
			boot_latched        <= next_boot_latched;
			read_state          <= next_read_state;
			bit_index           <= next_bit_index;
			clock_pin_prev      <= clock_pin_sync;
		end
	end

	// pin drive: output value is always low, the enable decides release
	logic data_release;
	logic clock_release;
	logic gates_off;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			data_release  <= 1'b0;
			clock_release <= 1'b0;
			gates_off     <= 1'b0;
		end else if (CLK_EN) begin
			if (next_read_state == short_fault_pkg::READ_SHIFT) begin
				// data flag carries the current bit, clock pin left to controller
				data_release  <= next_fault[next_bit_index];
				clock_release <= 1'b1;
			end else if (next_read_state == short_fault_pkg::READ_DONE) begin
				// after clear: persisting logic and regulator undervoltage and overtemperature shown at once, boot undervoltage and a live short only from the next cycle
				data_release  <= logic_uv || regulator_uv || over_temp;
				clock_release <= logic_uv || regulator_uv;
			end else begin
				data_release  <= logic_uv || (!clear_all && (regulator_uv ||
					next_boot_latched || over_temp));
				clock_release <= logic_uv || (!clear_all && (regulator_uv ||
					next_boot_latched || next_short_latched || any_short));
			end
			gates_off <= logic_uv || regulator_uv || next_boot_latched ||
				(SHUTDOWN_ON_FAULT && (next_short_latched || over_temp));
		end
	end

	assign FAULT_FLAG_DATA_OUT   = 1'b0;
	assign FAULT_FLAG_CLOCK_OUT  = 1'b0;
	assign FAULT_FLAG_DATA_OE_N  = data_release;
	assign FAULT_FLAG_CLOCK_OE_N = clock_release;
	assign GATES_DISABLED        = gates_off;
	assign FAULT_CAPTURE_SHIFT   = fault_capture_shift;

	// assertions
	sequence read_finished;
		reading && clock_fall && bit_index == short_fault_pkg::LAST_INDEX;
	endsequence

	AST_READ_CLEARS: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN and read_finished |=> (fault_capture_shift & ~$past(new_faults)) == 10'h000)
		else $error("register not cleared after read");
	AST_LOGIC_UV_CLEARS: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && logic_uv |=> fault_capture_shift == 10'h000 && data_release && clock_release)
		else $error("logic supply undervoltage did not clear register");
	AST_SHORT_STORED: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && !logic_uv && reset_n_sync && !read_end && low_short[0]
		|=> fault_capture_shift[short_fault_pkg::BIT_A_LOW])
		else $error("short not stored");
	AST_NO_LATCH_LOW: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && !SHUTDOWN_ON_FAULT && !short_latched |=> !short_latched)
		else $error("short latched with shutdown disabled");
	AST_LATCH_HIGH: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && SHUTDOWN_ON_FAULT && any_short && !clear_all && !logic_uv
		|=> short_latched && gates_off)
		else $error("short not latched with shutdown enabled");
	AST_OT_HOLDS_CLOCK: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && read_state == short_fault_pkg::READ_IDLE && over_temp && !clock_flag
		&& !(|boot_uv) |=> !clock_release)
		else $error("clock flag released for overtemperature alone");
	AST_BITS_STICKY: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && !clear_all && !logic_uv |=> (fault_capture_shift & $past(fault_capture_shift))
		== $past(fault_capture_shift))
		else $error("fault bit lost without clearing event");
	AST_BOOT_LATCH: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && |boot_uv && !clear_all && !logic_uv |=> boot_latched)
		else $error("boot undervoltage not latched");
	AST_FIRST_BIT: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && read_state == short_fault_pkg::READ_IDLE && read_allowed && clock_fall
		&& !logic_uv && reset_n_sync |=> reading && bit_index == 4'h0)
		else $error("read did not start at first bit");

	// named steps of the serial read
	sequence read_opened;
		CLK_EN && read_state == short_fault_pkg::READ_IDLE && read_allowed && clock_fall
			&& !logic_uv && reset_n_sync;
	endsequence
	sequence bit_advanced;
		CLK_EN && reading && clock_fall && bit_index != short_fault_pkg::LAST_INDEX
			&& !logic_uv && reset_n_sync;
	endsequence
	sequence read_closed;
		CLK_EN && reading && clock_fall && bit_index == short_fault_pkg::LAST_INDEX
			&& !logic_uv && reset_n_sync;
	endsequence

	AST_OPEN_SHOWS_FIRST: assert property (@(posedge REF_CLK) disable iff (RESET)
		read_opened |=> data_release == fault_capture_shift[short_fault_pkg::BIT_A_HIGH]
			&& clock_release)
		else $error("first bit not on the data flag");
	AST_NEXT_BIT: assert property (@(posedge REF_CLK) disable iff (RESET)
		bit_advanced |=> reading && bit_index == $past(bit_index) + 4'h1
			&& data_release == fault_capture_shift[bit_index])
		else $error("next bit not presented");
	AST_CLOSE_FLAGS: assert property (@(posedge REF_CLK) disable iff (RESET)
		read_closed |=> read_state == short_fault_pkg::READ_DONE
			&& clock_release == $past(regulator_uv)
			&& data_release == ($past(regulator_uv) || $past(over_temp)))
		else $error("flags wrong after the closing fall");
	AST_DONE_LEAVES: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && read_state == short_fault_pkg::READ_DONE
		|=> read_state == short_fault_pkg::READ_IDLE)
		else $error("read stuck after completion");
	AST_NO_READ_HOT: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && read_state == short_fault_pkg::READ_IDLE && over_temp |=> !reading)
		else $error("read started during overtemperature");
	AST_LIVE_FLAG: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && !SHUTDOWN_ON_FAULT && any_short && !clear_all
		&& next_read_state == short_fault_pkg::READ_IDLE |=> clock_release)
		else $error("live short not shown on the clock flag");
	AST_LIVE_FLAG_DROPS: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && !SHUTDOWN_ON_FAULT && !any_short && !short_latched && !boot_latched
		&& !(|boot_uv) && !regulator_uv && !logic_uv
		&& next_read_state == short_fault_pkg::READ_IDLE |=> !clock_release)
		else $error("clock flag held after the short went away");
	AST_BOOT_FLAGS: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && boot_latched && !clear_all && !logic_uv
		&& next_read_state == short_fault_pkg::READ_IDLE
		|=> data_release && clock_release && gates_off)
		else $error("latched boot undervoltage not flagged");
	AST_REG_UV_KEPT: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && regulator_uv && !logic_uv
		|=> fault_capture_shift[short_fault_pkg::BIT_REG_UV])
		else $error("regulator undervoltage bit not set");
	AST_HOT_DATA_FLAG: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && over_temp && !clear_all && next_read_state == short_fault_pkg::READ_IDLE
		|=> data_release)
		else $error("data flag not released when hot");
	AST_SHIFT_KEEPS_CLOCK: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && next_read_state == short_fault_pkg::READ_SHIFT |=> clock_release)
		else $error("clock flag pulled low during a read");
	AST_WINDING_BOTH: assert property (@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && high_short[0] && low_short[0] && !logic_uv
		|=> fault_capture_shift[short_fault_pkg::BIT_A_HIGH]
			&& fault_capture_shift[short_fault_pkg::BIT_A_LOW])
		else $error("shorted winding not stored on both sides");
endmodule : bridge_short_fault_register

// File: sim/fault_reader_model.sv
// controller model that clocks the fault register out over the clock flag
`timescale 1ns/10ps
module fault_reader_model #(
	parameter int HALF_NS = 200
) (
	// control from the bench
	input  wire logic  start,
	output logic       done,
	output logic [9:0] captured,
	// flag pin levels and the pull on the clock flag
	input  wire logic  clock_pin,
	input  wire logic  data_pin,
	output logic       pull_clock_low
);
	initial begin
		pull_clock_low = 1'b0;
		done = 1'b0;
		captured = 10'h000;
		forever begin
			@(posedge start);
			done = 1'b0;
			// a read only begins once the device has released the clock flag
			wait (clock_pin === 1'b1);
			for (int i = 0; i < 10; i++) begin
				pull_clock_low = 1'b1;
				#(HALF_NS);
				pull_clock_low = 1'b0;
				#(HALF_NS);
				// the bit stands until the next fall, so sample just before it
				captured[i] = data_pin;
			end
			pull_clock_low = 1'b1; // one more fall ends the read
			#(2 * HALF_NS);
			pull_clock_low = 1'b0; // let go of the pin once the device holds it
			done = 1'b1;
		end
	end
endmodule : fault_reader_model

// File: sim/bridge_short_fault_register_bench.sv
// self-checking bench for the short-fault register and its serial readout
`timescale 1ns/10ps
module bridge_short_fault_register_bench;
	typedef struct packed {
		logic       shutdown_on_fault;
		logic [2:0] high;
		logic [2:0] low;
		logic [9:0] reg_exp;
		logic       gates;
	} row_type;
	logic       ref_clk = 1'b0, reset = 1'b1, reset_n_pin = 1'b1, shutdown_on_fault = 1'b0;
	logic [2:0] high_on = 3'h0, low_on = 3'h0, high_over = 3'h0, low_over = 3'h0;
	logic       reg_uv = 1'b0, logic_uv = 1'b0, over_temp = 1'b0;
	logic [2:0] boot_uv = 3'h0;
	logic       data_out, data_oe_n, clk_out, clk_oe_n, gates, start = 1'b0, done, pull_low;
	logic [9:0] fault_reg, captured;
	wire logic  clock_wire = (clk_oe_n === 1'b0 || pull_low) ? 1'b0 : 1'b1;
	wire logic  data_wire = (data_oe_n === 1'b0) ? 1'b0 : 1'b1;
	int         miscompares = 0;
	int         checked = 0;
	row_type    rows [7] = '{
		'{1'b1, 3'h1, 3'h0, 10'h001, 1'b1}, '{1'b1, 3'h2, 3'h0, 10'h002, 1'b1},
		'{1'b1, 3'h4, 3'h0, 10'h004, 1'b1}, '{1'b1, 3'h0, 3'h1, 10'h008, 1'b1},
		'{1'b0, 3'h0, 3'h2, 10'h010, 1'b0}, '{1'b0, 3'h0, 3'h4, 10'h020, 1'b0},
		'{1'b0, 3'h1, 3'h1, 10'h009, 1'b0}};

	always #25 ref_clk = ~ref_clk;

	bridge_short_fault_register #(.BLANK(3)) i_dut (
		.REF_CLK(ref_clk), .RESET(reset), .CLK_EN(1'b1), .RESET_N_PIN(reset_n_pin),
		.SHUTDOWN_ON_FAULT(shutdown_on_fault), .HIGH_FET_ON(high_on), .LOW_FET_ON(low_on),
		.HIGH_OVER_THRESHOLD(high_over), .LOW_OVER_THRESHOLD(low_over),
		.REGULATOR_UV(reg_uv), .LOGIC_SUPPLY_UV(logic_uv), .OVER_TEMPERATURE(over_temp),
		.BOOT_UV(boot_uv), .FAULT_FLAG_DATA_IN(data_wire), .FAULT_FLAG_DATA_OUT(data_out),
		.FAULT_FLAG_DATA_OE_N(data_oe_n), .FAULT_FLAG_CLOCK_IN(clock_wire),
		.FAULT_FLAG_CLOCK_OUT(clk_out), .FAULT_FLAG_CLOCK_OE_N(clk_oe_n),
		.GATES_DISABLED(gates), .FAULT_CAPTURE_SHIFT(fault_reg));

	fault_reader_model i_reader (
		.start(start), .done(done), .captured(captured), .clock_pin(clock_wire),
		.data_pin(data_wire), .pull_clock_low(pull_low));

	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : step

	task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic pin_clear();
		reset_n_pin = 1'b0;
		step(5);
		reset_n_pin = 1'b1;
		step(5);
	endtask : pin_clear

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	initial begin
		#200000;
		miscompares++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial begin
		step(12);
		reset = 1'b0;
		step(4);
		check("register after reset", fault_reg, 10'h000);
		check("clock flag idle", clk_oe_n, 1'b0);
		check("data flag idle", data_oe_n, 1'b0);
		check("pin drive levels", {data_out, clk_out}, 2'b00);
		pin_clear();
		$display("reset test done");
		foreach (rows[i]) begin
			shutdown_on_fault = rows[i].shutdown_on_fault;
			high_on = 3'h7;
			low_on = 3'h7;
			high_over = rows[i].high;
			low_over = rows[i].low;
			step(12);
			check("register", fault_reg, rows[i].reg_exp);
			check("gates", gates, rows[i].gates);
			check("clock flag", clk_oe_n, 1'b1);
			check("data flag", data_oe_n, 1'b0);
			high_over = 3'h0;
			low_over = 3'h0;
			high_on = 3'h0;
			low_on = 3'h0;
			step(6);
			check("clock flag after", clk_oe_n, rows[i].shutdown_on_fault);
			check("register held", fault_reg, rows[i].reg_exp);
			pin_clear();
			check("register cleared", fault_reg, 10'h000);
			check("gates cleared", gates, 1'b0);
			$display("row %0d done", i);
		end
		high_over = 3'h7;
		low_over = 3'h7;
		step(10);
		low_on = 3'h7;
		high_on = 3'h7;
		step(1);
		high_over = 3'h0;
		low_over = 3'h0;
		step(8);
		check("blanked register", fault_reg, 10'h000);
		high_on = 3'h0;
		low_on = 3'h0;
		$display("blanking test done");
		shutdown_on_fault = 1'b1;
		high_on = 3'h1;
		low_on = 3'h4;
		high_over = 3'h1;
		low_over = 3'h4;
		boot_uv = 3'h2;
		step(12);
		boot_uv = 3'h0;
		high_over = 3'h0;
		low_over = 3'h0;
		high_on = 3'h0; // bridge protected before the read
		low_on = 3'h0;
		step(6);
		check("register before read", fault_reg, 10'h121);
		start = 1'b1;
		for (int n = 0; n < 400 && done !== 1'b1; n++) step(1);
		start = 1'b0;
		check("serial word", captured, 10'h121);
		check("register after read", fault_reg, 10'h000);
		check("clock flag after read", clk_oe_n, 1'b0);
		check("data flag after read", data_oe_n, 1'b0);
		$display("serial read test done");
		low_on = 3'h1;
		low_over = 3'h1;
		step(12);
		check("clock flag short after read", clk_oe_n, 1'b1);
		low_over = 3'h0;
		low_on = 3'h0;
		logic_uv = 1'b1;
		step(6);
		check("register in logic uv", fault_reg, 10'h000);
		check("data flag in logic uv", data_oe_n, 1'b1);
		check("clock flag in logic uv", clk_oe_n, 1'b1);
		logic_uv = 1'b0;
		step(6);
		check("clock flag after logic uv", clk_oe_n, 1'b0);
		$display("logic uv test done");
		over_temp = 1'b1;
		step(6);
		check("data flag hot", data_oe_n, 1'b1);
		check("clock flag hot", clk_oe_n, 1'b0);
		over_temp = 1'b0;
		step(6);
		check("data flag cooled", data_oe_n, 1'b0);
		$display("overtemperature test done");
		tally_and_finish();
	end
endmodule : bridge_short_fault_register_bench
